// >>> hss_core.sv
// Hot swap sequencer and serial slave, one mclk domain.
// Assumes pin and comparator inputs are asynchronous, an external ADC
// front end converting on request, and a strap decoder giving 2-bit codes.
// What this block does
// - Reset period: strong gate and timer pulldowns
// - Initial cycle starts with small timer pullup
// - Then large pulldown until timer low threshold
// - Enabled after initial cycle: start gate charge
// - Overcurrent charges timer; high threshold faults
// - Retry variant: small sink times cooldown
// - Retry variant: cooldown end restarts hot swap
// - Commands start voltage or current conversions
// - Results read back over two or three bytes
// - Pure slave, fast-mode serial clock rates
// - Address is 100 plus four strap bits
// - Upper strap high bits, lower strap low
// - Shift address and direction, MSB first
// - Acknowledge own address, else idle till start
// - First written byte is the command
// - Enable low: gate off, timer pulled down
// - Overcurrent gone: large sink, gate full on
// - Latch-off variant: reenable restarts after fault
module hss_core #(
    parameter bit AUTO_RETRY = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Asynchronous comparator and pin inputs
    input wire logic on_pin,
    input wire logic timer_high,
    input wire logic timer_low_threshold,
    input wire logic overcurrent_timing_threshold,
    input wire logic [1:0] addr_strap_high,
    input wire logic [1:0] addr_strap_low,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Gate and timer source enables
    output logic gate_pd_strong,
    output logic gate_pd_fault,
    output logic gate_pu_small,
    output logic gate_full_on,
    output logic timer_pu_5,
    output logic timer_pu_60,
    output logic timer_pd_2,
    output logic timer_pd_100,
    output logic fault_flag,
    // ADC front end
    output logic adc_start,
    output logic adc_sel_current,
    input wire logic adc_done,
    input wire logic [11:0] adc_data
);
    logic [2:0] s_on, s_th, s_tl, s_oc, s_scl, s_sda;
    logic f_on, f_th, f_tl, f_oc, f_scl, f_sda;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_on <= hss_pkg::SYNC_RST;
            s_th <= hss_pkg::SYNC_RST;
            s_tl <= hss_pkg::SYNC_RST;
            s_oc <= hss_pkg::SYNC_RST;
            s_scl <= 3'h7;
            s_sda <= 3'h7;
            f_on <= 1'b0;
            f_th <= 1'b0;
            f_tl <= 1'b0;
            f_oc <= 1'b0;
            f_scl <= 1'b1;
            f_sda <= 1'b1;
        end else begin
            s_on <= {s_on[1:0], on_pin};
            s_th <= {s_th[1:0], timer_high};
            s_tl <= {s_tl[1:0], timer_low_threshold};
            s_oc <= {s_oc[1:0], overcurrent_timing_threshold};
            s_scl <= {s_scl[1:0], scl_in};
            s_sda <= {s_sda[1:0], sda_in};
            if (s_on[1] == s_on[2]) f_on <= s_on[2];
            if (s_th[1] == s_th[2]) f_th <= s_th[2];
            if (s_tl[1] == s_tl[2]) f_tl <= s_tl[2];
            if (s_oc[1] == s_oc[2]) f_oc <= s_oc[2];
            if (s_scl[1] == s_scl[2]) f_scl <= s_scl[2];
            if (s_sda[1] == s_sda[2]) f_sda <= s_sda[2];
        end
    end

    // Sequencer
    hss_pkg::hss_seq_t st_r, st_nxt;
    logic [5:0] por_r, por_nxt;
    logic fault_r, fault_nxt;
    always_comb begin
        st_nxt = st_r;
        por_nxt = por_r;
        fault_nxt = fault_r;
        case (st_r)
            hss_pkg::HSS_POR: begin
                if (por_r == 6'(hss_pkg::POR_CYC - 1)) st_nxt = hss_pkg::HSS_INIT_UP;
                else por_nxt = por_r + 6'h01;
            end
            hss_pkg::HSS_INIT_UP: if (f_tl) st_nxt = hss_pkg::HSS_INIT_DN;
            hss_pkg::HSS_INIT_DN: if (!f_tl) st_nxt = hss_pkg::HSS_WAIT_ON;
            hss_pkg::HSS_WAIT_ON: if (f_on) st_nxt = hss_pkg::HSS_RUN;
            hss_pkg::HSS_RUN: begin
                // fault when timer hits high threshold
                if (f_oc && f_th) begin
                    fault_nxt = 1'b1;
                    st_nxt = AUTO_RETRY ? hss_pkg::HSS_FAULT_COOL : hss_pkg::HSS_LATCHED;
                end
            end
            hss_pkg::HSS_FAULT_COOL: if (!f_tl) begin
                fault_nxt = 1'b0;
                st_nxt = hss_pkg::HSS_RUN;
            end
            hss_pkg::HSS_LATCHED: if (!f_on) begin
                fault_nxt = 1'b0;
                st_nxt = hss_pkg::HSS_WAIT_ON;
            end
            default: st_nxt = hss_pkg::HSS_POR;
        endcase
        if (!f_on && (st_r == hss_pkg::HSS_RUN || st_r == hss_pkg::HSS_FAULT_COOL)) begin
            st_nxt = hss_pkg::HSS_WAIT_ON;
            fault_nxt = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= hss_pkg::HSS_POR;
            por_r <= 6'h00;
            fault_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            por_r <= por_nxt;
            fault_r <= fault_nxt;
        end
    end
    always_comb begin
        gate_pd_strong = st_r == hss_pkg::HSS_POR || st_r == hss_pkg::HSS_INIT_UP
                      || st_r == hss_pkg::HSS_INIT_DN || st_r == hss_pkg::HSS_WAIT_ON;
        gate_pd_fault = st_r == hss_pkg::HSS_FAULT_COOL || st_r == hss_pkg::HSS_LATCHED;
        gate_pu_small = st_r == hss_pkg::HSS_RUN;
        // gate full on once overcurrent clears
        gate_full_on = st_r == hss_pkg::HSS_RUN && !f_oc;
        timer_pu_5 = st_r == hss_pkg::HSS_INIT_UP;
        timer_pu_60 = st_r == hss_pkg::HSS_RUN && f_oc;
        timer_pd_2 = st_r == hss_pkg::HSS_FAULT_COOL;
        timer_pd_100 = st_r == hss_pkg::HSS_POR || st_r == hss_pkg::HSS_INIT_DN
                    || st_r == hss_pkg::HSS_WAIT_ON || st_r == hss_pkg::HSS_LATCHED
                    || (st_r == hss_pkg::HSS_RUN && !f_oc);
        fault_flag = fault_r;
    end

    // Serial slave, oversampled on mclk
    // 25 mclk per half period at 400 kHz
    logic scl_d, sda_d;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= f_scl;
            sda_d <= f_sda;
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = f_scl && !scl_d;
    assign scl_fall = !f_scl && scl_d;
    assign start_c = f_scl && scl_d && sda_d && !f_sda;
    assign stop_c = f_scl && scl_d && !sda_d && f_sda;
    // own address from base and straps
    // upper strap gives bits three and two
    logic [6:0] own_addr;
    assign own_addr = {hss_pkg::ADDR_BASE, addr_strap_high, addr_strap_low};
    hss_pkg::hss_i2c_t is_r, is_nxt;
    logic [7:0] sh_r, sh_nxt, cmd_r, cmd_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [1:0] byte_r, byte_nxt;
    logic first_r, first_nxt, ack_r, ack_nxt, sda_r, sda_nxt;
    logic [11:0] v_r, v_nxt, i_r, i_nxt;
    logic [1:0] need_r, need_nxt;
    logic conv_r, conv_nxt, cur_r, cur_nxt, go_r, go_nxt;
    logic [7:0] rd_byte;
    always_comb begin
        // voltage high, current high, shared low nibbles
        case (byte_r)
            2'h0: rd_byte = cmd_r[hss_pkg::CMD_STATUS] ? {6'h00, fault_r, 1'b0}
                          : (cmd_r[hss_pkg::CMD_I_ONCE] && !cmd_r[hss_pkg::CMD_V_ONCE])
                          ? i_r[11:4] : v_r[11:4];
            2'h1: rd_byte = cmd_r[hss_pkg::CMD_V_ONCE] && cmd_r[hss_pkg::CMD_I_ONCE]
                          ? i_r[11:4] : {v_r[3:0], i_r[3:0]};
            default: rd_byte = {v_r[3:0], i_r[3:0]};
        endcase
    end
    always_comb begin
        is_nxt = is_r;
        sh_nxt = sh_r;
        cmd_nxt = cmd_r;
        bit_nxt = bit_r;
        byte_nxt = byte_r;
        first_nxt = first_r;
        ack_nxt = ack_r;
        sda_nxt = sda_r;
        v_nxt = v_r;
        i_nxt = i_r;
        need_nxt = need_r;
        conv_nxt = conv_r;
        cur_nxt = cur_r;
        go_nxt = 1'b0;
        // sequence requested conversions through the mux
        if (!conv_r && need_r != 2'h0) begin
            cur_nxt = !need_r[0];
            conv_nxt = 1'b1;
            go_nxt = 1'b1;
        end else if (conv_r && adc_done) begin
            conv_nxt = 1'b0;
            if (cur_r) i_nxt = adc_data;
            else v_nxt = adc_data;
            need_nxt = cur_r ? {1'b0, need_r[0]} : {need_r[1], 1'b0};
        end
        // shift bits on rising clock, MSB first
        if (scl_rise && is_r != hss_pkg::HSS_I_IDLE) begin
            sh_nxt = {sh_r[6:0], f_sda};
            if (is_r == hss_pkg::HSS_I_RACK && f_sda) is_nxt = hss_pkg::HSS_I_IDLE;
        end
        if (scl_fall) begin
            case (is_r)
                hss_pkg::HSS_I_ADDR, hss_pkg::HSS_I_WR: begin
                    if (bit_r == hss_pkg::BIT_LAST) begin
                        bit_nxt = 4'h0;
                        if (is_r == hss_pkg::HSS_I_ADDR && sh_r[7:1] != own_addr)
                            is_nxt = hss_pkg::HSS_I_IDLE;
                        else begin
                            sda_nxt = 1'b0;
                            is_nxt = is_r == hss_pkg::HSS_I_ADDR ? hss_pkg::HSS_I_AACK
                                     : hss_pkg::HSS_I_WACK;
                            ack_nxt = sh_r[0];
                        end
                        if (is_r == hss_pkg::HSS_I_WR) first_nxt = 1'b0;
                        if (is_r == hss_pkg::HSS_I_WR && first_r && !sh_r[hss_pkg::CMD_EXT]) begin
                            cmd_nxt = sh_r;
                            need_nxt = {sh_r[hss_pkg::CMD_I_ONCE] | sh_r[hss_pkg::CMD_I_CONT],
                                        sh_r[hss_pkg::CMD_V_ONCE] | sh_r[hss_pkg::CMD_V_CONT]};
                        end
                    end else bit_nxt = bit_r + 4'h1;
                end
                hss_pkg::HSS_I_AACK, hss_pkg::HSS_I_RACK: begin
                    if (is_r == hss_pkg::HSS_I_RACK || ack_r) begin
                        is_nxt = hss_pkg::HSS_I_RD;
                        sda_nxt = rd_byte[7];
                        sh_nxt = rd_byte;
                        byte_nxt = byte_r + 2'h1;
                    end else begin
                        is_nxt = hss_pkg::HSS_I_WR;
                        sda_nxt = 1'b1;
                    end
                end
                hss_pkg::HSS_I_WACK: begin
                    is_nxt = hss_pkg::HSS_I_WR;
                    sda_nxt = 1'b1;
                end
                hss_pkg::HSS_I_RD: begin
                    if (bit_r == hss_pkg::BIT_LAST) begin
                        bit_nxt = 4'h0;
                        sda_nxt = 1'b1;
                        is_nxt = hss_pkg::HSS_I_RACK;
                    end else begin
                        bit_nxt = bit_r + 4'h1;
                        sda_nxt = sh_r[7];
                    end
                end
                default: sda_nxt = 1'b1;
            endcase
        end
        if (stop_c) begin
            is_nxt = hss_pkg::HSS_I_IDLE;
            sda_nxt = 1'b1;
        end
        if (start_c) begin
            is_nxt = hss_pkg::HSS_I_ADDR;
            bit_nxt = hss_pkg::BIT_START;
            byte_nxt = 2'h0;
            first_nxt = 1'b1;
            sda_nxt = 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            is_r <= hss_pkg::HSS_I_IDLE;
            sh_r <= hss_pkg::CMD_RST;
            cmd_r <= hss_pkg::CMD_RST;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            first_r <= 1'b0;
            ack_r <= 1'b0;
            sda_r <= 1'b1;
            v_r <= hss_pkg::ADC_RST;
            i_r <= hss_pkg::ADC_RST;
            need_r <= 2'h0;
            conv_r <= 1'b0;
            cur_r <= 1'b0;
            go_r <= 1'b0;
        end else begin
            is_r <= is_nxt;
            sh_r <= sh_nxt;
            cmd_r <= cmd_nxt;
            bit_r <= bit_nxt;
            byte_r <= byte_nxt;
            first_r <= first_nxt;
            ack_r <= ack_nxt;
            sda_r <= sda_nxt;
            v_r <= v_nxt;
            i_r <= i_nxt;
            need_r <= need_nxt;
            conv_r <= conv_nxt;
            cur_r <= cur_nxt;
            go_r <= go_nxt;
        end
    end
    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = !sda_r;
    assign adc_start = go_r;
    assign adc_sel_current = cur_r;
endmodule

// >>> hss_pkg.sv
// Package for the hot swap sequencer with serial slave front end.
// Assumes a 20 MHz mclk and comparator flags already made digital.
package hss_pkg;
    localparam int CLK_HZ = 20_000_000;
    // Fastest serial clock that the slave keeps up with
    localparam int SCL_MAX_HZ = 400_000;
    // Cycles per half period of the fastest serial clock, rounded down
    localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_MAX_HZ);
    // Length of the power-up reset period held on the gate and timer
    localparam int POR_NS = 1000;
    localparam int POR_CYC = (POR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [2:0] ADDR_BASE = 3'h1 << 2;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // The start's own clock fall wraps this count to bit zero
    localparam logic [3:0] BIT_START = 4'hF;
    // Command byte fields
    localparam int CMD_EXT = 7;
    localparam int CMD_V_CONT = 0;
    localparam int CMD_V_ONCE = 1;
    localparam int CMD_I_CONT = 2;
    localparam int CMD_I_ONCE = 3;
    localparam int CMD_STATUS = 6;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [11:0] ADC_RST = 12'h000;
    localparam logic [2:0] SYNC_RST = 3'h0;

    typedef enum logic [2:0] {
        HSS_POR, HSS_INIT_UP, HSS_INIT_DN, HSS_WAIT_ON,
        HSS_RUN, HSS_FAULT_COOL, HSS_LATCHED
    } hss_seq_t;

    typedef enum logic [2:0] {
        HSS_I_IDLE, HSS_I_ADDR, HSS_I_AACK, HSS_I_WR, HSS_I_WACK, HSS_I_RD, HSS_I_RACK
    } hss_i2c_t;
endpackage

// >>> hss_core_assertions.sv
// Concurrent checks on the sequencer and serial slave pins.
// Assumes the bench holds each comparator input for many cycles.
module hss_core_assertions #(
    parameter bit AUTO_RETRY = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Pins and flags
    input wire logic on_pin,
    input wire logic timer_high,
    input wire logic timer_low_threshold,
    input wire logic scl_in,
    input wire logic sda_oe,
    // Source enables
    input wire logic gate_pd_strong,
    input wire logic gate_pd_fault,
    input wire logic gate_pu_small,
    input wire logic gate_full_on,
    input wire logic timer_pu_5,
    input wire logic timer_pu_60,
    input wire logic timer_pd_2,
    input wire logic timer_pd_100,
    input wire logic fault_flag,
    input wire logic adc_start
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    chk_por_pulldowns: assert property (
        $rose(nrst) |-> (gate_pd_strong && timer_pd_100) [*8]) else $error("reset pulldowns off");
    chk_init_pullup: assert property (
        (timer_pu_5 && !timer_low_threshold) [*4] |=> timer_pu_5) else $error("pullup dropped early");
    chk_init_sink: assert property (
        $fell(timer_pu_5) |-> timer_pd_100 && $past(timer_low_threshold, 2))
        else $error("initial sink wrong");
    chk_fault_declare: assert property (
        $rose(fault_flag) |-> $past(timer_high, 2) ##[0:2] (gate_pd_fault && !gate_pu_small))
        else $error("fault without high threshold");
    chk_cool_sink: assert property (
        AUTO_RETRY && $rose(fault_flag) |-> ##[0:2] timer_pd_2) else $error("no cooldown sink");
    chk_retry_start: assert property (
        AUTO_RETRY && $fell(timer_pd_2) && on_pin |-> ##[0:3] gate_pu_small)
        else $error("no retry after cooldown");
    chk_oc_clear: assert property (
        gate_full_on |-> timer_pd_100 && !timer_pu_60) else $error("full gate with timer up");
    chk_enable_low: assert property (
        (!on_pin) [*8] |-> !gate_pu_small && !gate_full_on) else $error("gate on while disabled");
    chk_ack_edge: assert property (
        $changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
    chk_adc_pulse: assert property (
        adc_start |=> !adc_start) else $error("start pulse too long");

    cover property ($rose(fault_flag));
    cover property (sda_oe && scl_in);
    cover property (adc_start);
endmodule

bind hss_core hss_core_assertions #(.AUTO_RETRY(AUTO_RETRY)) u_chk (
    .mclk, .nrst, .on_pin, .timer_high, .timer_low_threshold, .scl_in, .sda_oe,
    .gate_pd_strong, .gate_pd_fault, .gate_pu_small, .gate_full_on, .timer_pu_5,
    .timer_pu_60, .timer_pd_2, .timer_pd_100, .fault_flag, .adc_start
);

// >>> hss_i2c_master.sv
// Serial bus master model, open-drain data line.
// Assumes the bench resolves SDA with a pull-up; SCL is never stretched.
module hss_i2c_master (
    // Clock and resolved data line
    input wire logic mclk,
    input wire logic sda,
    // Clock level and data pull-low
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic start();
        sda_low = 1'b1;
        wt(25);
        scl = 1'b0;
    endtask
    // Data moves well after the clock fall, clear of the slave sync
    task automatic bit_io(input logic b, output logic r);
        wt(5);
        sda_low = !b;
        wt(20);
        scl = 1'b1;
        wt(25);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, ack);
    endtask
    task automatic stop();
        wt(5);
        sda_low = 1'b1;
        wt(20);
        scl = 1'b1;
        wt(25);
        sda_low = 1'b0;
        wt(25);
    endtask
endmodule

// >>> testbench.sv
// Self-checking bench for hss_core with a serial master and ADC stub.
// Assumes a 50 ns mclk and comparator pins held steady per step.
`define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
        n_fail++; \
        $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] V_VAL = 12'hA5C;
    localparam logic [11:0] I_VAL = 12'h3B7;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic on_pin = 1'b0, timer_high = 1'b0, timer_low_threshold = 1'b0;
    logic overcurrent_timing_threshold = 1'b0, adc_done = 1'b0;
    logic [1:0] addr_strap_high = 2'h0, addr_strap_low = 2'h0;
    logic [11:0] adc_data = 12'h000;
    logic scl_in, sda_in, sda_low, sda_out, sda_oe, fault_flag, adc_start, adc_sel_current;
    logic gate_pd_strong, gate_pd_fault, gate_pu_small, gate_full_on;
    logic timer_pu_5, timer_pu_60, timer_pd_2, timer_pd_100;
    logic [7:0] q;
    logic [6:0] own;
    logic ack;
    int n_fail = 0;
    int cmp_count = 0;
    int n_start = 0;

    always #25 mclk = ~mclk;
    assign sda_in = !(sda_oe || sda_low);
    hss_core u_dut (.mclk, .nrst, .on_pin, .timer_high, .timer_low_threshold,
        .overcurrent_timing_threshold, .addr_strap_high, .addr_strap_low, .scl_in,
        .sda_in, .sda_out, .sda_oe, .gate_pd_strong, .gate_pd_fault, .gate_pu_small,
        .gate_full_on, .timer_pu_5, .timer_pu_60, .timer_pd_2, .timer_pd_100,
        .fault_flag, .adc_start, .adc_sel_current, .adc_done, .adc_data);
    hss_i2c_master u_master (.mclk, .sda(sda_in), .scl(scl_in), .sda_low);

    // Latch-off variant shares the sequencer inputs; its bus stays idle
    logic lat_pd_fault, lat_pu_small, lat_fault;
    hss_core #(.AUTO_RETRY(1'b0)) u_dut_latch (.mclk, .nrst, .on_pin, .timer_high,
        .timer_low_threshold, .overcurrent_timing_threshold, .addr_strap_high,
        .addr_strap_low, .scl_in(1'b1), .sda_in(1'b1), .sda_out(), .sda_oe(),
        .gate_pd_strong(), .gate_pd_fault(lat_pd_fault), .gate_pu_small(lat_pu_small),
        .gate_full_on(), .timer_pu_5(), .timer_pu_60(), .timer_pd_2(), .timer_pd_100(),
        .fault_flag(lat_fault), .adc_start(), .adc_sel_current(), .adc_done(1'b0),
        .adc_data(12'h000));

    // Converter stub answers four cycles after each start
    always @(negedge mclk) begin
        adc_done <= 1'b0;
        if (adc_start === 1'b1) begin
            n_start <= n_start + 1;
            repeat (4) @(negedge mclk);
            adc_data <= adc_sel_current ? I_VAL : V_VAL;
            adc_done <= 1'b1;
        end
    end

    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic t_power_up();
        wt(2);
        `CHK("reset pulldowns", 2'b11, {gate_pd_strong, timer_pd_100})
        wt(30);
        `CHK("initial pullup", 1'b1, timer_pu_5)
        timer_low_threshold = 1'b1;
        on_pin = 1'b1;
        wt(10);
        `CHK("initial sink", 3'b010, {timer_pu_5, timer_pd_100, gate_pu_small})
        timer_low_threshold = 1'b0;
        wt(10);
        `CHK("gate charge", 1'b1, gate_pu_small)
    endtask
    task automatic t_address();
        for (int k = 0; k < 4; k++) begin
            addr_strap_high = 2'(k);
            addr_strap_low = 2'(3 - k);
            wt(10);
            u_master.start();
            u_master.xfer({3'b100, 2'(k), 2'(3 - k), 1'b0}, 1'b1, q, ack);
            u_master.stop();
            `CHK("own address ack", 1'b0, ack)
            `CHK("sda drive level", 1'b0, sda_out)
            u_master.start();
            u_master.xfer({3'b100, 2'(3 - k), 2'(k), 1'b0}, 1'b1, q, ack);
            u_master.stop();
            `CHK("foreign address nack", 1'b1, ack)
        end
    endtask
    task automatic t_read();
        own = {3'b100, addr_strap_high, addr_strap_low};
        // Command written first to choose what the read returns
        u_master.start();
        u_master.xfer({own, 1'b0}, 1'b1, q, ack);
        u_master.xfer(8'h0A, 1'b1, q, ack);
        `CHK("command ack", 1'b0, ack)
        u_master.stop();
        wt(40);
        `CHK("conversions", 2, n_start)
        u_master.start();
        u_master.xfer({own, 1'b1}, 1'b1, q, ack);
        `CHK("read address ack", 1'b0, ack)
        u_master.xfer(8'hFF, 1'b0, q, ack);
        `CHK("voltage high", V_VAL[11:4], q)
        u_master.xfer(8'hFF, 1'b0, q, ack);
        `CHK("current high", I_VAL[11:4], q)
        // Last byte left unacknowledged, then stop
        u_master.xfer(8'hFF, 1'b1, q, ack);
        u_master.stop();
        `CHK("low nibbles", {V_VAL[3:0], I_VAL[3:0]}, q)
    endtask
    task automatic t_oc_clear();
        overcurrent_timing_threshold = 1'b1;
        timer_low_threshold = 1'b1;
        wt(10);
        `CHK("fault timing", 2'b10, {timer_pu_60, timer_pd_100})
        overcurrent_timing_threshold = 1'b0;
        timer_low_threshold = 1'b0;
        wt(10);
        `CHK("gate full on", 3'b110, {gate_full_on, timer_pd_100, timer_pu_60})
    endtask
    task automatic t_enable_low();
        on_pin = 1'b0;
        wt(10);
        `CHK("disabled", 3'b001, {gate_pu_small, gate_full_on, timer_pd_100})
        on_pin = 1'b1;
        wt(10);
        `CHK("reenabled", 1'b1, gate_pu_small)
    endtask
    task automatic t_fault_retry();
        overcurrent_timing_threshold = 1'b1;
        timer_low_threshold = 1'b1;
        wt(10);
        timer_high = 1'b1;
        wt(10);
        `CHK("fault gate", 3'b101, {gate_pd_fault, gate_pu_small, fault_flag})
        `CHK("cooldown sink", 1'b1, timer_pd_2)
        overcurrent_timing_threshold = 1'b0;
        timer_high = 1'b0;
        wt(10);
        `CHK("cooldown hold", 2'b01, {gate_pu_small, fault_flag})
        // Status read while the fault is still shown
        u_master.start();
        u_master.xfer({own, 1'b0}, 1'b1, q, ack);
        u_master.xfer(8'h40, 1'b1, q, ack);
        u_master.stop();
        u_master.start();
        u_master.xfer({own, 1'b1}, 1'b1, q, ack);
        u_master.xfer(8'hFF, 1'b1, q, ack);
        u_master.stop();
        `CHK("status byte", 8'h02, q)
        timer_low_threshold = 1'b0;
        wt(10);
        `CHK("retry", 2'b10, {gate_pu_small, fault_flag})
        `CHK("latched off", 3'b101, {lat_pd_fault, lat_pu_small, lat_fault})
    endtask
    task automatic t_latch_off();
        on_pin = 1'b0;
        wt(10);
        `CHK("latch cleared", 2'b00, {lat_fault, lat_pu_small})
        on_pin = 1'b1;
        wt(10);
        `CHK("latch restart", 2'b10, {lat_pu_small, lat_fault})
    endtask

    initial begin
        wt(20);
        nrst = 1'b1;
        t_power_up();
        t_address();
        t_read();
        t_oc_clear();
        t_enable_low();
        t_fault_retry();
        t_latch_off();
        complete_run();
    end
    // Whole sequence needs about 9600 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        complete_run();
    end
endmodule
